//--- rtl/cssr_pkg.sv
// Constants, types and decode functions shared by the clock select and start-up reset block
package cssr_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] CSSR_ADDR_GPR1    = 8'h2A;
    localparam logic [7:0] CSSR_ADDR_STATUS  = 8'h2B;
    localparam logic [7:0] CSSR_ADDR_SLEEP   = 8'h2C;

    // Field positions in the sleep control register
    localparam int CSSR_SLEEP_EN_BIT   = 0;
    localparam int CSSR_SLEEP_MODE_LSB = 1;

    // Values after reset: shipped fuse setting and cleared registers
    localparam logic [3:0] CSSR_CLOCK_SOURCE_SELECT_FUSES_DEFAULT = 4'h2;
    localparam logic [1:0] CSSR_SUT_DEFAULT   = 2'h2;
    localparam logic       CSSR_DIV8_DEFAULT  = 1'b0;
    localparam logic [7:0] CSSR_GPR1_RESET    = 8'h00;
    localparam logic [2:0] CSSR_SLEEP_MODE_RESET = 3'h0;

    // Reset time-out lengths in watchdog oscillator cycles
    localparam logic [15:0] CSSR_TOUT_NONE  = 16'h0000;
    localparam logic [15:0] CSSR_TOUT_SHORT = 16'h0200;
    localparam logic [15:0] CSSR_TOUT_LONG  = 16'h2000;

    // Oscillator stabilisation lengths in oscillator cycles
    localparam logic [15:0] CSSR_SU_EXT      = 16'h0006;
    localparam logic [15:0] CSSR_SU_RES_SHRT = 16'h0102;
    localparam logic [15:0] CSSR_SU_RES_LONG = 16'h0400;
    localparam logic [15:0] CSSR_SU_XTAL     = 16'h4000;
    localparam logic [15:0] CSSR_SU_LOWFREQ  = 16'h8000;

    // Sleep mode encodings
    localparam logic [2:0] CSSR_SM_IDLE     = 3'h0;
    localparam logic [2:0] CSSR_SM_ADCNR    = 3'h1;
    localparam logic [2:0] CSSR_SM_PDOWN    = 3'h2;
    localparam logic [2:0] CSSR_SM_PSAVE    = 3'h3;
    localparam logic [2:0] CSSR_SM_STANDBY  = 3'h6;
    localparam logic [2:0] CSSR_SM_XSTANDBY = 3'h7;

    typedef enum logic [2:0] {
        CSSR_SRC_LOWPOWER_XTAL,
        CSSR_SRC_FULLSWING_XTAL,
        CSSR_SRC_LOWFREQ_XTAL,
        CSSR_SRC_RC_128K,
        CSSR_SRC_RC_CAL,
        CSSR_SRC_EXTERNAL,
        CSSR_SRC_RESERVED
    } cssr_source_t;

    typedef enum logic [2:0] {
        CSSR_ST_HOLD,
        CSSR_ST_TIMEOUT,
        CSSR_ST_STARTUP,
        CSSR_ST_RUN,
        CSSR_ST_SLEEP
    } cssr_state_t;

    // A fuse reads zero when programmed
    function automatic logic cssr_programmed(input logic fuseBit);
        cssr_programmed = ~fuseBit;
    endfunction : cssr_programmed

    // Clock source kind from the four select fuses
    function automatic cssr_source_t cssr_decode_source(input logic [3:0] sel);
        if (sel[3])
            cssr_decode_source = CSSR_SRC_LOWPOWER_XTAL;
        else if (sel[3:1] == 3'h3)
            cssr_decode_source = CSSR_SRC_FULLSWING_XTAL;
        else if (sel[3:1] == 3'h2)
            cssr_decode_source = CSSR_SRC_LOWFREQ_XTAL;
        else if (sel == 4'h3)
            cssr_decode_source = CSSR_SRC_RC_128K;
        else if (sel == 4'h2)
            cssr_decode_source = CSSR_SRC_RC_CAL;
        else if (sel == 4'h0)
            cssr_decode_source = CSSR_SRC_EXTERNAL;
        else
            cssr_decode_source = CSSR_SRC_RESERVED;
    endfunction : cssr_decode_source

    function automatic logic cssr_is_xtal(input cssr_source_t src);
        cssr_is_xtal = (src == CSSR_SRC_LOWPOWER_XTAL) || (src == CSSR_SRC_FULLSWING_XTAL);
    endfunction : cssr_is_xtal

    // Time-out length from the start-up and select fuses
    function automatic logic [15:0] cssr_timeout_cycles(input logic [3:0] sel, input logic [1:0] startup_time_fuses);
        logic [2:0] code;
        code = {sel[0], startup_time_fuses};
        if (cssr_is_xtal(cssr_decode_source(sel)))
        begin
            case (code)
                3'h2, 3'h5: cssr_timeout_cycles = CSSR_TOUT_NONE;
                3'h0, 3'h3, 3'h6: cssr_timeout_cycles = CSSR_TOUT_SHORT;
                default: cssr_timeout_cycles = CSSR_TOUT_LONG;
            endcase
        end
        else
        begin
            case (startup_time_fuses)
                2'h0: cssr_timeout_cycles = CSSR_TOUT_NONE;
                2'h1: cssr_timeout_cycles = CSSR_TOUT_SHORT;
                default: cssr_timeout_cycles = CSSR_TOUT_LONG;
            endcase
        end
    endfunction : cssr_timeout_cycles

    // Stabilisation length from the clock type
    function automatic logic [15:0] cssr_startup_cycles(input logic [3:0] sel, input logic [1:0] startup_time_fuses);
        logic [2:0] code;
        code = {sel[0], startup_time_fuses};
        case (cssr_decode_source(sel))
            CSSR_SRC_LOWFREQ_XTAL: cssr_startup_cycles = CSSR_SU_LOWFREQ;
            CSSR_SRC_LOWPOWER_XTAL, CSSR_SRC_FULLSWING_XTAL:
            begin
                if (code < 3'h2)
                    cssr_startup_cycles = CSSR_SU_RES_SHRT;
                else if (code < 3'h5)
                    cssr_startup_cycles = CSSR_SU_RES_LONG;
                else
                    cssr_startup_cycles = CSSR_SU_XTAL;
            end
            default: cssr_startup_cycles = CSSR_SU_EXT;
        endcase
    endfunction : cssr_startup_cycles

endpackage : cssr_pkg

//--- rtl/cssr_cycle_counter.sv
// Loadable down-counter of oscillator ticks with a sticky done flag
`timescale 1ns/1ps
module cssr_cycle_counter
    import cssr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] target,
    input  wire logic        tick,
    output logic             done
);

    typedef struct packed {
        logic [15:0] count;
        logic        busy;
        logic        done;
    } cssr_cnt_state_t;

    cssr_cnt_state_t s;
    cssr_cnt_state_t next_s;

    // A zero target finishes at once; done holds until the next start
    always_comb
    begin
        next_s = s;
        if (start)
        begin
            next_s.count = target;
            next_s.busy  = (target != 16'h0000);
            next_s.done  = (target == 16'h0000);
        end
        else if (s.busy && tick)
        begin
            next_s.count = s.count - 16'h0001;
            if (s.count == 16'h0001)
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign done = s.done;

endmodule : cssr_cycle_counter

//--- rtl/cssr_top.sv
// Clock source decode, start-up reset sequencing, sleep gating of clock domains and a spare byte register
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// R1: Decode four select fuses into source kind
// R2: Fuse bit zero means programmed
// R3: Reset defaults to calibrated RC, divide eight
// R4: Extra time-out reset after other resets release
// R5: Time-out is 0, 512 or 8192 ticks
// R6: Count oscillator ticks, then release internal reset
// R7: Stabilisation count depends on clock type
// R8: Wake from power-down/save uses start-up only
// R9: Core clock stops with core in sleep
// R10: Peripheral clock gated; wake input stays live
// R11: Flash clock follows core clock
// R12: Async timer clock survives power-save sleep
// R13: Converter clock runs while core, peripheral stop
// R14: Each domain gated per sleep mode
// R15: Software: skip time-out only with brownout_detector
// R16: Byte register, read/write, resets to zero
// R17: Clocks gated until both counts complete
module cssr_top
    import cssr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] clockSourceSelectFuses,
    input  wire logic [1:0] startupTimeFuses,
    input  wire logic       divideByEightFuse,
    input  wire logic       otherResetActive,
    input  wire logic       watchdogTick,
    input  wire logic       oscillatorTick,
    input  wire logic       sleepRequest,
    input  wire logic       wakeEvent,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWriteData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regReadData,
    output logic            internalReset,
    output logic            coreClockEn,
    output logic            ioClockEn,
    output logic            flashClockEn,
    output logic            asyncTimerClockEn,
    output logic            converterClockEn,
    output logic            divideByEight,
    output logic [2:0]      clockSourceKind
);

    typedef struct packed {
        cssr_state_t state;
        logic [3:0]  clock_source_select_fuses;
        logic [1:0]  startup_time_fuses;
        logic        div8;
        logic        coldStart;
        logic        loadTimeout;
        logic        loadStartup;
        logic [2:0]  sleepMode;
        logic        sleepEnable;
        logic [7:0]  gpr1;
        logic [7:0]  readData;
        logic        intReset;
        logic        coreEn;
        logic        ioEn;
        logic        flashEn;
        logic        asyEn;
        logic        adcEn;
        logic [2:0]  kind;
    } cssr_top_state_t;

    cssr_top_state_t s;
    cssr_top_state_t next_s;
    logic            timeoutDone;
    logic            startupDone;

    // Time-out runs on watchdog oscillator ticks
    cssr_cycle_counter u_timeout (
        .clk    (clk),
        .rst    (rst),
        .start  (s.loadTimeout),
        .target (cssr_timeout_cycles(s.clock_source_select_fuses, s.startup_time_fuses)), // R5
        .tick   (watchdogTick),
        .done   (timeoutDone)
    );

    // Stabilisation runs on the selected oscillator's ticks
    cssr_cycle_counter u_startup (
        .clk    (clk),
        .rst    (rst),
        .start  (s.loadStartup),
        .target (cssr_startup_cycles(s.clock_source_select_fuses, s.startup_time_fuses)), // R7
        .tick   (oscillatorTick), // R6
        .done   (startupDone)
    );

    // Valid sleep encodings only; reserved codes ignore the request
    function automatic logic modeValid(input logic [2:0] mode);
        modeValid = (mode == CSSR_SM_IDLE) || (mode == CSSR_SM_ADCNR) || (mode == CSSR_SM_PDOWN)
                    || (mode == CSSR_SM_PSAVE) || (mode == CSSR_SM_STANDBY) || (mode == CSSR_SM_XSTANDBY);
    endfunction : modeValid

    // Oscillator stops in these modes, so a wake must re-stabilise it
    function automatic logic needsStartup(input logic [2:0] mode);
        needsStartup = (mode == CSSR_SM_PDOWN) || (mode == CSSR_SM_PSAVE);
    endfunction : needsStartup

    // Sequencing, sleep gating and register access in one next-state pass
    always_comb
    begin
        next_s             = s;
        next_s.loadTimeout = 1'b0;
        next_s.loadStartup = 1'b0;
        next_s.readData    = 8'h00;

        case (s.state)
            CSSR_ST_HOLD:
            begin
                if (!otherResetActive)
                begin
                    // Fuses captured once, as the other resets let go
                    next_s.clock_source_select_fuses       = clockSourceSelectFuses;
                    next_s.startup_time_fuses         = startupTimeFuses;
                    next_s.div8        = cssr_programmed(divideByEightFuse); // R2
                    next_s.loadTimeout = 1'b1;
                    next_s.coldStart   = 1'b1;
                    next_s.state       = CSSR_ST_TIMEOUT; // R4
                end
            end
            CSSR_ST_TIMEOUT:
            begin
                if (!s.loadTimeout && timeoutDone)
                begin
                    next_s.loadStartup = 1'b1;
                    next_s.state       = CSSR_ST_STARTUP; // R8
                end
            end
            CSSR_ST_STARTUP:
            begin
                if (!s.loadStartup && startupDone)
                begin
                    next_s.coldStart = 1'b0;
                    next_s.state     = CSSR_ST_RUN; // R6 R17
                end
            end
            CSSR_ST_RUN:
            begin
                if (sleepRequest && s.sleepEnable && modeValid(s.sleepMode))
                    next_s.state = CSSR_ST_SLEEP;
            end
            CSSR_ST_SLEEP:
            begin
                // Wake input is sampled on clk in every sleep mode, whatever the domain gating
                if (wakeEvent) // R10
                begin
                    if (needsStartup(s.sleepMode))
                    begin
                        next_s.loadStartup = 1'b1;
                        next_s.state       = CSSR_ST_STARTUP; // R8
                    end
                    else
                        next_s.state = CSSR_ST_RUN;
                end
            end
            default:
                next_s.state = CSSR_ST_HOLD;
        endcase

        // Any other reset source wins over every state
        if (otherResetActive)
        begin
            next_s.state       = CSSR_ST_HOLD; // R4
            next_s.loadTimeout = 1'b0;
            next_s.loadStartup = 1'b0;
        end

        // Internal reset covers the cold start only, not a wake
        next_s.intReset = (next_s.state == CSSR_ST_HOLD) || (next_s.state == CSSR_ST_TIMEOUT)
                          || ((next_s.state == CSSR_ST_STARTUP) && next_s.coldStart); // R4 R6

        // Clock domain gating per state and sleep mode
        next_s.coreEn = 1'b0;
        next_s.ioEn   = 1'b0;
        next_s.asyEn  = 1'b0;
        next_s.adcEn  = 1'b0;
        if (next_s.state == CSSR_ST_RUN) // R17
        begin
            next_s.coreEn = 1'b1;
            next_s.ioEn   = 1'b1;
            next_s.asyEn  = 1'b1;
            next_s.adcEn  = 1'b1;
        end
        else if (next_s.state == CSSR_ST_SLEEP) // R14
        begin
            case (s.sleepMode)
                CSSR_SM_IDLE:
                begin
                    next_s.ioEn  = 1'b1; // R9
                    next_s.asyEn = 1'b1;
                    next_s.adcEn = 1'b1;
                end
                CSSR_SM_ADCNR:
                begin
                    next_s.asyEn = 1'b1;
                    next_s.adcEn = 1'b1; // R13
                end
                CSSR_SM_PSAVE, CSSR_SM_XSTANDBY:
                    next_s.asyEn = 1'b1; // R12
                default:
                    next_s.asyEn = 1'b0;
            endcase
        end
        next_s.flashEn = next_s.coreEn; // R11
        next_s.kind    = 3'(cssr_decode_source(next_s.clock_source_select_fuses)); // R1

        // Register writes; sleep control is accepted in any state, a new mode acts from the next cycle, also within a sleep
        if (regWrite)
        begin
            case (regAddr)
                CSSR_ADDR_GPR1:
                    next_s.gpr1 = regWriteData; // R16
                CSSR_ADDR_SLEEP:
                begin
                    next_s.sleepEnable = regWriteData[CSSR_SLEEP_EN_BIT];
                    next_s.sleepMode   = regWriteData[CSSR_SLEEP_MODE_LSB +: 3];
                end
                default:
                    next_s.gpr1 = s.gpr1;
            endcase
        end

        // Reads answer one cycle later; unmapped offsets read zero
        if (regRead)
        begin
            case (regAddr)
                CSSR_ADDR_GPR1:
                    next_s.readData = s.gpr1; // R16
                CSSR_ADDR_STATUS:
                    next_s.readData = {s.div8, s.kind, 1'b0, 3'(s.state)};
                CSSR_ADDR_SLEEP:
                    next_s.readData = {4'h0, s.sleepMode, s.sleepEnable};
                default:
                    next_s.readData = 8'h00;
            endcase
        end
    end

    // Reset loads the shipped fuse setting, so clocks start as delivered
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s             <= '0;
            s.state       <= CSSR_ST_HOLD;
            s.clock_source_select_fuses       <= CSSR_CLOCK_SOURCE_SELECT_FUSES_DEFAULT; // R3
            s.startup_time_fuses         <= CSSR_SUT_DEFAULT;
            s.div8        <= ~CSSR_DIV8_DEFAULT;
            s.coldStart   <= 1'b1;
            s.sleepMode   <= CSSR_SLEEP_MODE_RESET;
            s.gpr1        <= CSSR_GPR1_RESET; // R16
            s.intReset    <= 1'b1;
            s.kind        <= 3'(CSSR_SRC_RC_CAL);
        end
        else
            s <= next_s;
    end

    assign regReadData       = s.readData;
    assign internalReset     = s.intReset;
    assign coreClockEn       = s.coreEn;
    assign ioClockEn         = s.ioEn;
    assign flashClockEn      = s.flashEn;
    assign asyncTimerClockEn = s.asyEn;
    assign converterClockEn  = s.adcEn;
    assign divideByEight     = s.div8;
    assign clockSourceKind   = s.kind;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_on_other: assert property (otherResetActive |=> internalReset) // R4
        else $error("internal reset not held while another reset is active");
    a_clocks_gated_reset: assert property (internalReset |-> !coreClockEn && !ioClockEn) // R17
        else $error("clocks running during internal reset");
    a_flash_core_pair: assert property (flashClockEn == coreClockEn) // R11
        else $error("flash clock differs from core clock");
    a_gpr_write_read: assert property ((regWrite && regAddr == CSSR_ADDR_GPR1) ##1
        (regRead && !regWrite && regAddr == CSSR_ADDR_GPR1) |=> regReadData == $past(regWriteData, 2)) // R16
        else $error("byte register lost written value");
    a_gpr_reset_zero: assert property (s.state == CSSR_ST_HOLD && $past(rst) |-> s.gpr1 == 8'h00) // R16
        else $error("byte register not zero after reset");
    a_wake_skips_timeout: assert property (s.state == CSSR_ST_SLEEP && !otherResetActive
        |=> s.state != CSSR_ST_TIMEOUT && !internalReset) // R8
        else $error("wake applied the reset time-out");
    a_wake_restarts_osc: assert property (s.state == CSSR_ST_SLEEP && wakeEvent && !otherResetActive
        && needsStartup(s.sleepMode) |=> s.state == CSSR_ST_STARTUP ##1 !coreClockEn) // R8
        else $error("power-down wake skipped stabilisation");
    a_async_in_psave: assert property (s.state == CSSR_ST_SLEEP && s.sleepMode == CSSR_SM_PSAVE
        |-> asyncTimerClockEn && !ioClockEn) // R12
        else $error("async timer clock gated in power-save");
    a_adc_noise_mode: assert property (s.state == CSSR_ST_SLEEP && s.sleepMode == CSSR_SM_ADCNR
        |-> converterClockEn && !ioClockEn && !coreClockEn) // R13
        else $error("converter sleep gating wrong");
    a_idle_gating: assert property (s.state == CSSR_ST_SLEEP && s.sleepMode == CSSR_SM_IDLE
        |-> ioClockEn && !coreClockEn) // R9 R10 R14
        else $error("idle sleep gating wrong");
    a_source_decode: assert property (clockSourceKind == 3'(cssr_decode_source(s.clock_source_select_fuses))) // R1
        else $error("clock source kind does not match select fuses");
    a_run_needs_counts: assert property (s.state == CSSR_ST_STARTUP && $past(s.state) == CSSR_ST_STARTUP
        && !startupDone && !otherResetActive |=> !coreClockEn) // R6 R7
        else $error("core clock before stabilisation finished");

    c_cold_start: cover property (s.state == CSSR_ST_TIMEOUT ##[1:300] s.state == CSSR_ST_RUN);
    c_psave_wake: cover property (s.state == CSSR_ST_SLEEP && s.sleepMode == CSSR_SM_PSAVE ##1
        s.state == CSSR_ST_STARTUP);
    c_idle_wake: cover property (s.state == CSSR_ST_SLEEP && s.sleepMode == CSSR_SM_IDLE ##1
        s.state == CSSR_ST_RUN);
    c_gpr_readback: cover property (regRead && regAddr == CSSR_ADDR_GPR1 ##1 regReadData != 8'h00);

endmodule : cssr_top

//--- tb/cssr_osc_model.sv
// Oscillator and watchdog oscillator tick source on the far side of the block
`timescale 1ns/1ps
module cssr_osc_model
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic oscRun,
    input  wire logic slowOsc,
    output logic      watchdogTick,
    output logic      oscillatorTick
);
    logic [1:0] phase;

    // Watchdog oscillator always runs; the selected one only once started, fast or slow
    always_ff @(posedge clk)
    begin
        phase          <= rst ? 2'h0 : phase + 2'h1;
        watchdogTick   <= !rst && phase[0];
        oscillatorTick <= !rst && oscRun && (slowOsc ? (phase == 2'h3) : phase[0]);
    end
endmodule : cssr_osc_model

//--- tb/tb.sv
// Self-checking bench for the clock select and start-up reset block
`timescale 1ns/1ps
module tb
    import cssr_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] clockSourceSelectFuses = 4'h2;
    logic [1:0] startupTimeFuses = 2'h2;
    logic       divideByEightFuse = 1'b0;
    logic       otherResetActive = 1'b1;
    logic       oscRun = 1'b0;
    logic       slowOsc = 1'b0;
    logic       sleepRequest = 1'b0;
    logic       wakeEvent = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regReadData;
    logic [2:0] clockSourceKind;
    logic       internalReset, coreClockEn, ioClockEn, flashClockEn;
    logic       asyncTimerClockEn, converterClockEn, divideByEight;
    logic       watchdogTick, oscillatorTick;
    int         wdCount = 0;
    int         oscCount = 0;
    int         failures = 0;
    int         n_compared = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    // Running tick totals; scenarios only use differences
    always @(posedge clk)
    begin
        wdCount <= wdCount + int'(watchdogTick);
        oscCount <= oscCount + int'(oscillatorTick);
    end

    cssr_top uut
    (
        .clk, .rst, .clockSourceSelectFuses, .startupTimeFuses, .divideByEightFuse, .otherResetActive,
        .watchdogTick, .oscillatorTick, .sleepRequest, .wakeEvent, .regAddr, .regWriteData, .regWrite,
        .regRead, .regReadData, .internalReset, .coreClockEn, .ioClockEn, .flashClockEn,
        .asyncTimerClockEn, .converterClockEn, .divideByEight, .clockSourceKind
    );

    cssr_osc_model osc
    (
        .clk, .rst, .oscRun, .slowOsc, .watchdogTick, .oscillatorTick
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic rng(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : rng

    task automatic results();
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic hang(input string what);
        failures++;
        $display("FAIL %s expected finish seen hang", what);
        results();
    endtask : hang

    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr

    // Read data stand only in the cycle after the strobe
    task automatic regRd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regReadData;
    endtask : regRd

    task automatic nudge(input logic toSleep);
        @(posedge clk);
        sleepRequest <= toSleep;
        wakeEvent <= !toSleep;
        @(posedge clk);
        sleepRequest <= 1'b0;
        wakeEvent <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : nudge

    task automatic resetAndRegs();
        logic [7:0] d;
        repeat (5) @(posedge clk);
        #1;
        chk("internalReset", 1, internalReset);
        chk("enables", 0, {coreClockEn, ioClockEn, flashClockEn, asyncTimerClockEn, converterClockEn});
        chk("kind", 4, clockSourceKind);
        chk("divideByEight", 1, divideByEight);
        regRd(CSSR_ADDR_GPR1, d);
        chk("byte reset", 0, d);
        regWr(CSSR_ADDR_GPR1, 8'h55);
        regRd(CSSR_ADDR_GPR1, d);
        chk("byte", 8'h55, d);
        regWr(CSSR_ADDR_GPR1, 8'hAA);
        regWr(8'h00, 8'hFF);
        regRd(8'h00, d);
        chk("unmapped", 0, d);
        regRd(CSSR_ADDR_GPR1, d);
        chk("byte", 8'hAA, d);
        @(posedge clk);
        #1;
        chk("read data after its cycle", 0, regReadData);
    endtask : resetAndRegs

    // Every select code, with the divide fuse toggled alongside
    task automatic decode();
        logic [2:0] k;
        for (int s = 0; s < 16; s++)
        begin
            case (s)
                0: k = 3'h5;
                1: k = 3'h6;
                2: k = 3'h4;
                3: k = 3'h3;
                4, 5: k = 3'h2;
                6, 7: k = 3'h1;
                default: k = 3'h0;
            endcase
            @(posedge clk);
            clockSourceSelectFuses <= 4'(s);
            divideByEightFuse <= s[0];
            otherResetActive <= 1'b1;
            repeat (2) @(posedge clk);
            otherResetActive <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            chk("kind", k, clockSourceKind);
            chk("divideByEight", !s[0], divideByEight);
        end
    endtask : decode

    // Oscillator held still until the time-out phase ends, so both counts show apart
    task automatic startup(input logic [3:0] s, input logic [1:0] u, input int tout, input int su, input logic slow);
        logic [7:0] d;
        int base;
        int n;
        @(posedge clk);
        oscRun <= 1'b0;
        slowOsc <= slow;
        clockSourceSelectFuses <= s;
        startupTimeFuses <= u;
        divideByEightFuse <= 1'b1;
        otherResetActive <= 1'b1;
        repeat (3) @(posedge clk);
        otherResetActive <= 1'b0;
        base = wdCount;
        d = 8'h00;
        n = 0;
        while (d[2:0] !== 3'h2)
        begin
            if (++n > 20000)
                hang("time-out");
            regRd(CSSR_ADDR_STATUS, d);
            chk("held", 1, internalReset);
        end
        rng("watchdog ticks", tout, tout + 3, wdCount - base);
        @(posedge clk);
        oscRun <= 1'b1;
        base = oscCount;
        n = 0;
        while (internalReset !== 1'b0)
        begin
            if (++n > 2000)
                hang("start-up");
            chk("gated", 0, {coreClockEn, ioClockEn, flashClockEn, asyncTimerClockEn, converterClockEn});
            @(posedge clk);
            #1;
        end
        rng("osc ticks", su, su + 3, oscCount - base);
        chk("enables", 5'h1F, {coreClockEn, ioClockEn, flashClockEn, asyncTimerClockEn, converterClockEn});
        chk("divideByEight", 0, divideByEight);
    endtask : startup

    task automatic sleepModes();
        logic [2:0] modes[6] = '{CSSR_SM_IDLE, CSSR_SM_ADCNR, CSSR_SM_PDOWN, CSSR_SM_PSAVE,
                                 CSSR_SM_STANDBY, CSSR_SM_XSTANDBY};
        logic [2:0] keep[6] = '{3'h7, 3'h3, 3'h0, 3'h2, 3'h0, 3'h2};
        logic [7:0] d;
        int n;
        regWr(CSSR_ADDR_SLEEP, {4'h0, CSSR_SM_IDLE, 1'b0});
        nudge(1'b1);
        chk("sleep refused", 1, coreClockEn);
        for (int i = 0; i < 6; i++)
        begin
            regWr(CSSR_ADDR_SLEEP, {4'h0, modes[i], 1'b1});
            regRd(CSSR_ADDR_SLEEP, d);
            chk("sleep control", {4'h0, modes[i], 1'b1}, d);
            nudge(1'b1);
            chk("core flash", 0, {coreClockEn, flashClockEn});
            chk("io asy adc", keep[i], {ioClockEn, asyncTimerClockEn, converterClockEn});
            nudge(1'b0);
            n = 0;
            while (coreClockEn !== 1'b1)
            begin
                if (++n > 200)
                    hang("wake");
                chk("wake reset", 0, internalReset);
                @(posedge clk);
                #1;
            end
            chk("flash", 1, flashClockEn);
        end
    endtask : sleepModes

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        resetAndRegs();
        decode();
        // Time-out stays enabled except on the external clock, where a brownout_detector is assumed
        startup(4'h2, 2'h1, 512, 6, 1'b1);
        startup(4'h8, 2'h0, 512, 258, 1'b0);
        startup(4'h3, 2'h2, 8192, 6, 1'b0);
        startup(4'h0, 2'h0, 0, 6, 1'b0);
        sleepModes();
        results();
    end
endmodule : tb
